/* shared/pwm_mon_pkg.sv */
// Constants and types for the constant resolution PWM / frequency monitor.
// Assumes a 125 MHz system clock and a 32-bit AXI4-Lite register port.
package pwm_mon_pkg;

  // ----------------------------------------------------------------
  // Register map (index form, byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [9:0] IDX_DIVIDER = 10'h0a0;
  localparam logic [9:0] IDX_ON_TIME = 10'h0a1;
  localparam logic [9:0] IDX_CONTROL = 10'h0a2;
  localparam logic [9:0] IDX_STATUS = 10'h0a3;
  localparam int ADDR_W = 12;

  // ----------------------------------------------------------------
  // Control register fields
  // ----------------------------------------------------------------
  localparam int CTL_MODE = 0;
  localparam int CTL_RUN = 1;
  localparam int CTL_IRQ_EN = 2;
  localparam int CTL_PEND = 3;
  localparam int CTL_PIN_A_EN = 4;
  localparam int CTL_PIN_B_EN = 5;
  localparam int CTL_EDGE_SEL = 6;

  // Status register fields
  localparam int STS_OUT = 8;
  localparam int STS_MON = 9;

  // ----------------------------------------------------------------
  // Reset values and timing
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_DIVIDER = 8'h00;
  localparam logic [7:0] RST_ON_TIME = 8'h00;
  localparam logic [7:0] PWM_LAST_COUNT = 8'hfe;
  localparam logic [7:0] ON_TIME_FULL = 8'hff;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic {
    MODE_MONITOR = 1'b0,
    MODE_PWM = 1'b1
  } wave_mode_t;

  // Software visible control bits
  typedef struct packed {
    logic active_edge_select;
    logic pin_b_output_enable;
    logic pin_a_output_enable;
    logic timer_event_pending;
    logic timer_irq_enable;
    logic timer_run;
    wave_mode_t waveform_mode_select;
  } waveform_timer_control_t;

  // Whole state of the block
  typedef struct packed {
    waveform_timer_control_t ctl;
    logic [7:0] clock_divider_value;
    logic [7:0] on_time_count;
    logic [7:0] cmp;
    logic [7:0] cnt;
    logic [7:0] psc;
    logic out;
    logic sync1;
    logic sync2;
    logic mon_prev;
    logic pin_a_o;
    logic pin_a_oe_n;
    logic pin_b_o;
    logic pin_b_oe_n;
    logic irq;
    logic awready;
    logic wready;
    logic [ADDR_W-1:0] awaddr;
    logic aw_full;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic w_full;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } state_t;

endpackage

/* hw/const_res_pwm_freq_monitor.sv */
// Eight bit PWM timer with a frequency monitor mode, AXI4-Lite registers.
// Assumes pin direction bits and halt come from logic on clk_sys; the
// monitor pin is asynchronous and is synchronised here.
//
// Chosen here: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/100ps

// Overview of operation
// - PWM period is a fixed 255 prescaled clocks.
// - Prescaler divides the system clock by divider value plus one.
// - PWM mode selected but stopped drives the timer output high.
// - Running PWM: low after on-time counts, high again after 255.
// - PWM waveform appears on enabled output pins A and B.
// - Writing run 1 while stopped starts and reinitialises the counter, 0 stops it.
// - On-time writes in running PWM take effect at next overflow.
// - Each PWM overflow sets pending; interrupt if enable is set.
// - Pending clears on written 0, ignores 1; hardware set wins.
// - PWM output set on overflow, cleared when count reaches on-time.
// - Monitor mode while stopped holds the timer output low.
// - Monitor mode drives pin B, and pin A too, when each is enabled.
// - Selected monitor edge clears counter and output; count goes on.
// - Pin A enabled in monitor mode feeds the output back as input.
// - Monitor output high while count exceeds on-time, low on edge.
// - Monitor count passing on-time sets pending flag.
// - Mode change while running toggles output; rise to monitor pends.
// - Lowering on-time below count in monitor mode sets pending.
// - Halt freezes the timer; it resumes its mode afterwards.
// - Divider writes take effect at the next prescaler underflow.
// - PWM on-time 0 stays low, 255 stays high; monitor immediate.
module const_res_pwm_freq_monitor
  import pwm_mon_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  // AXI4-Lite slave
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Pins and system
  input wire logic freq_monitor_input,
  output logic output_pin_a,
  output logic output_pin_a_oe_n,
  output logic output_pin_b,
  output logic output_pin_b_oe_n,
  input wire logic pin_a_dir_out,
  input wire logic pin_b_dir_out,
  input wire logic halt,
  output logic timer_irq
);

  state_t s_q;
  state_t s_d;

  // Combinational helpers, also watched by the checks
  logic wr_fire;
  logic wr_ctrl;
  logic start;
  logic mode_chg;
  logic tick;
  logic pwm_ovf;
  logic edge_evt;
  logic hw_set;
  logic mon_lvl;
  logic feed_back;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    logic [9:0] widx;
    logic [9:0] ridx;
    logic [7:0] wb;
    logic was_run;
    logic out_was;
    logic mon_upd;
    widx = s_q.awaddr[11:2];
    ridx = s_axi_araddr[11:2];
    wb = s_q.wdata[7:0];
    was_run = s_q.ctl.timer_run;
    out_was = s_q.out;
    mon_upd = 1'b0;
    s_d = s_q;
    wr_ctrl = 1'b0;
    start = 1'b0;
    mode_chg = 1'b0;
    tick = 1'b0;
    pwm_ovf = 1'b0;
    edge_evt = 1'b0;
    hw_set = 1'b0;

    // ---------------------------------------------------------------
    // Write channels: address and data taken in either order
    // ---------------------------------------------------------------
    if (s_axi_awvalid && s_q.awready) begin
      s_d.awaddr = s_axi_awaddr;
      s_d.aw_full = 1'b1;
      s_d.awready = 1'b0;
    end
    if (s_axi_wvalid && s_q.wready) begin
      s_d.wdata = s_axi_wdata;
      s_d.wstrb = s_axi_wstrb;
      s_d.w_full = 1'b1;
      s_d.wready = 1'b0;
    end
    wr_fire = s_q.aw_full && s_q.w_full && !s_q.bvalid;
    if (wr_fire) begin
      s_d.aw_full = 1'b0;
      s_d.w_full = 1'b0;
      s_d.bvalid = 1'b1;
      s_d.bresp = RESP_OKAY;
      unique case (widx)
        IDX_DIVIDER: begin
          if (s_q.wstrb[0]) begin
            s_d.clock_divider_value = wb;
          end
        end
        IDX_ON_TIME: begin
          if (s_q.wstrb[0]) begin
            s_d.on_time_count = wb;
          end
        end
        IDX_CONTROL: begin
          if (s_q.wstrb[0]) begin
            wr_ctrl = 1'b1;
            s_d.ctl.waveform_mode_select = wave_mode_t'(wb[CTL_MODE]);
            s_d.ctl.timer_run = wb[CTL_RUN];
            s_d.ctl.timer_irq_enable = wb[CTL_IRQ_EN];
            s_d.ctl.pin_a_output_enable = wb[CTL_PIN_A_EN];
            s_d.ctl.pin_b_output_enable = wb[CTL_PIN_B_EN];
            s_d.ctl.active_edge_select = wb[CTL_EDGE_SEL];
          end
        end
        IDX_STATUS: begin
          s_d.bresp = RESP_OKAY;
        end
        default: begin
          s_d.bresp = RESP_SLVERR;
        end
      endcase
    end
    if (s_q.bvalid && s_axi_bready) begin
      s_d.bvalid = 1'b0;
      s_d.awready = 1'b1;
      s_d.wready = 1'b1;
    end

    // ---------------------------------------------------------------
    // Read channel
    // ---------------------------------------------------------------
    if (s_axi_arvalid && s_q.arready) begin
      s_d.arready = 1'b0;
      s_d.rvalid = 1'b1;
      s_d.rdata = 32'h0000_0000;
      s_d.rresp = RESP_OKAY;
      unique case (ridx)
        IDX_DIVIDER: s_d.rdata[7:0] = s_q.clock_divider_value;
        IDX_ON_TIME: s_d.rdata[7:0] = s_q.on_time_count;
        IDX_CONTROL: s_d.rdata[6:0] = s_q.ctl;
        IDX_STATUS: begin
          s_d.rdata[7:0] = s_q.cnt;
          s_d.rdata[STS_OUT] = s_q.out;
          s_d.rdata[STS_MON] = s_q.sync2;
        end
        default: s_d.rresp = RESP_SLVERR;
      endcase
    end
    if (s_q.rvalid && s_axi_rready) begin
      s_d.rvalid = 1'b0;
      s_d.arready = 1'b1;
    end

    // ---------------------------------------------------------------
    // Monitor input source
    // ---------------------------------------------------------------
    s_d.sync1 = freq_monitor_input;
    s_d.sync2 = s_q.sync1;
    // A mis-configured pin A drives the timer output, so read that back
    feed_back = (s_q.ctl.waveform_mode_select == MODE_MONITOR) &&
                s_q.ctl.pin_a_output_enable && pin_a_dir_out;
    mon_lvl = feed_back ? s_q.out : s_q.sync2;

    // ---------------------------------------------------------------
    // Timer, frozen entirely while halted
    // ---------------------------------------------------------------
    if (!halt) begin
      s_d.mon_prev = mon_lvl;
      // Reload takes the register only at underflow or on start
      if (s_q.psc == 8'h00) begin
        tick = 1'b1;
        s_d.psc = s_d.clock_divider_value;
      end else begin
        s_d.psc = s_q.psc - 8'h01;
      end
      start = s_d.ctl.timer_run && !was_run;
      mode_chg = s_d.ctl.timer_run && was_run &&
                 (s_d.ctl.waveform_mode_select !=
                  s_q.ctl.waveform_mode_select);
      edge_evt = s_q.ctl.active_edge_select ?
                 (s_q.mon_prev && !mon_lvl) : (!s_q.mon_prev && mon_lvl);
      if (!s_d.ctl.timer_run) begin
        s_d.out = s_d.ctl.waveform_mode_select == MODE_PWM;
        edge_evt = 1'b0;
      end else if (start) begin
        // Counter restarts in step with a fresh prescaler period
        s_d.cnt = 8'h00;
        s_d.psc = s_d.clock_divider_value;
        s_d.cmp = s_d.on_time_count;
        s_d.out = (s_d.ctl.waveform_mode_select == MODE_PWM) &&
                  (s_d.on_time_count != 8'h00);
        edge_evt = 1'b0;
      end else if (mode_chg) begin
        s_d.out = !s_q.out;
        s_d.cmp = s_d.on_time_count;
        edge_evt = 1'b0;
      end else if (s_d.ctl.waveform_mode_select == MODE_PWM) begin
        edge_evt = 1'b0;
        if (tick) begin
          if (s_q.cnt == PWM_LAST_COUNT) begin
            pwm_ovf = 1'b1;
            s_d.cnt = 8'h00;
            s_d.cmp = s_d.on_time_count;
            s_d.out = s_d.on_time_count != 8'h00;
            hw_set = 1'b1;
          end else begin
            s_d.cnt = s_q.cnt + 8'h01;
            // Full-scale compare never trips, so 255 stays high
            s_d.out = (s_d.cnt < s_q.cmp) ||
                      (s_q.cmp == ON_TIME_FULL);
          end
        end
      end else begin
        if (edge_evt) begin
          s_d.cnt = 8'h00;
          mon_upd = 1'b1;
        end else if (tick) begin
          s_d.cnt = s_q.cnt + 8'h01; // Wrap to zero is the overflow
          mon_upd = 1'b1;
        end
        if (wr_fire && widx == IDX_ON_TIME) begin
          mon_upd = 1'b1;
        end
        if (mon_upd) begin
          s_d.out = s_d.cnt > s_d.on_time_count;
        end
      end
      // Any rise of the monitor output is a too-slow event
      if (s_d.ctl.timer_run && !start &&
          s_d.ctl.waveform_mode_select == MODE_MONITOR &&
          !out_was && s_d.out) begin
        hw_set = 1'b1;
      end
    end

    // ---------------------------------------------------------------
    // Pending flag: software clears with 0, hardware set wins
    // ---------------------------------------------------------------
    if (wr_ctrl && !wb[CTL_PEND]) begin
      s_d.ctl.timer_event_pending = 1'b0;
    end
    if (hw_set) begin
      s_d.ctl.timer_event_pending = 1'b1;
    end
    s_d.irq = s_d.ctl.timer_event_pending &&
              s_d.ctl.timer_irq_enable;

    // ---------------------------------------------------------------
    // Pin drive, registered so outputs come from flops
    // ---------------------------------------------------------------
    s_d.pin_a_oe_n = !(s_d.ctl.pin_a_output_enable && pin_a_dir_out);
    s_d.pin_a_o = s_d.out && !s_d.pin_a_oe_n;
    s_d.pin_b_oe_n = !(s_d.ctl.pin_b_output_enable && pin_b_dir_out);
    s_d.pin_b_o = s_d.out && !s_d.pin_b_oe_n;
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      s_q <= '0;
      s_q.clock_divider_value <= RST_DIVIDER;
      s_q.on_time_count <= RST_ON_TIME;
      s_q.pin_a_oe_n <= 1'b1;
      s_q.pin_b_oe_n <= 1'b1;
      s_q.awready <= 1'b1;
      s_q.wready <= 1'b1;
      s_q.arready <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  assign s_axi_awready = s_q.awready;
  assign s_axi_wready = s_q.wready;
  assign s_axi_bvalid = s_q.bvalid;
  assign s_axi_bresp = s_q.bresp;
  assign s_axi_arready = s_q.arready;
  assign s_axi_rvalid = s_q.rvalid;
  assign s_axi_rdata = s_q.rdata;
  assign s_axi_rresp = s_q.rresp;
  assign output_pin_a = s_q.pin_a_o;
  assign output_pin_a_oe_n = s_q.pin_a_oe_n;
  assign output_pin_b = s_q.pin_b_o;
  assign output_pin_b_oe_n = s_q.pin_b_oe_n;
  assign timer_irq = s_q.irq;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_period_wrap: assert property (
    @(posedge clk_sys) disable iff (rst)
    pwm_ovf |=> s_q.cnt == 8'h00 && $past(s_q.cnt) == 8'hfe &&
                s_q.ctl.timer_event_pending)
    else $error("PWM period did not wrap after count 254");

  a_prescale_reload: assert property (
    @(posedge clk_sys) disable iff (rst)
    tick && !start |=> s_q.psc == $past(s_d.clock_divider_value))
    else $error("Prescaler did not reload from divider value");

  a_idle_pwm_high: assert property (
    @(posedge clk_sys) disable iff (rst)
    !halt && !s_d.ctl.timer_run &&
    s_d.ctl.waveform_mode_select == MODE_PWM |=> s_q.out
    ##1 (s_q.pin_a_oe_n || s_q.pin_a_o == s_q.out))
    else $error("Stopped PWM mode output not high");

  a_idle_mon_low: assert property (
    @(posedge clk_sys) disable iff (rst)
    !halt && !s_d.ctl.timer_run &&
    s_d.ctl.waveform_mode_select == MODE_MONITOR |=> !s_q.out)
    else $error("Stopped monitor mode output not low");

  a_start_clears: assert property (
    @(posedge clk_sys) disable iff (rst)
    start |=> s_q.cnt == 8'h00 && s_q.ctl.timer_run)
    else $error("Start did not reinitialise the counter");

  a_cmp_hold: assert property (
    @(posedge clk_sys) disable iff (rst)
    !$stable(s_q.cmp) |-> $past(pwm_ovf || start || mode_chg))
    else $error("Compare value changed outside overflow");

  a_pend_set_wins: assert property (
    @(posedge clk_sys) disable iff (rst)
    hw_set |=> s_q.ctl.timer_event_pending)
    else $error("Hardware set of pending was lost");

  a_pend_clear: assert property (
    @(posedge clk_sys) disable iff (rst)
    wr_ctrl && !s_q.wdata[CTL_PEND] && !hw_set
    |=> !s_q.ctl.timer_event_pending)
    else $error("Pending flag not cleared by written zero");

  a_irq_follows: assert property (
    @(posedge clk_sys) disable iff (rst)
    hw_set && s_d.ctl.timer_irq_enable |=> timer_irq)
    else $error("Interrupt not raised with enable set");

  a_pin_b_gate: assert property (
    @(posedge clk_sys) disable iff (rst)
    output_pin_b |-> $past(s_d.ctl.pin_b_output_enable && pin_b_dir_out))
    else $error("Pin B driven without enable");

  a_edge_clears: assert property (
    @(posedge clk_sys) disable iff (rst)
    edge_evt |=> s_q.cnt == 8'h00 && !s_q.out)
    else $error("Monitor edge did not clear counter and output");

  a_halt_freeze: assert property (
    @(posedge clk_sys) disable iff (rst)
    halt |=> $stable(s_q.cnt) && $stable(s_q.psc) && $stable(s_q.out))
    else $error("Timer state moved during halt");

endmodule

/* sim/edge_source.sv */
// Far side model: square wave source on the frequency monitor pin.
// Assumes run and half come from the bench on clk_sys.
`timescale 1ns/100ps
module edge_source (
  input wire logic clk_sys,
  input wire logic run,
  input wire logic [7:0] half,
  input wire logic pin_a,
  input wire logic pin_a_oe_n,
  output logic level
);
  logic sq;

  initial begin
    sq = 1'b0;
  end

  // Toggles a few ns after an edge, so the pin is out of phase with clk_sys
  always begin
    @(posedge clk_sys);
    if (run) begin
      repeat (half) @(posedge clk_sys);
      sq <= #3 ~sq;
    end
  end

  // A timer driving pin A wins the shared wire over the source
  assign level = pin_a_oe_n ? sq : pin_a;
endmodule

/* sim/tb_const_res_pwm_freq_monitor.sv */
// Self-checking bench for the PWM / frequency monitor block.
// Assumes the AXI4-Lite timing given with the design and a 125 MHz clock.
`timescale 1ns/100ps
module tb_const_res_pwm_freq_monitor;
  import pwm_mon_pkg::*;
  localparam logic [11:0] A_DIV = {IDX_DIVIDER, 2'b00};
  localparam logic [11:0] A_ON = {IDX_ON_TIME, 2'b00};
  localparam logic [11:0] A_CTL = {IDX_CONTROL, 2'b00};
  localparam logic [11:0] A_STS = {IDX_STATUS, 2'b00};
  localparam logic [11:0] A_BAD = 12'h2fc;
  logic clk_sys, rst, awv, awr, wv, wrdy, bv, br, arv, arr, rv, rr;
  logic [11:0] awa, ara;
  logic [31:0] wd, rdd;
  logic [3:0] ws;
  logic [1:0] bresp, rresp;
  logic mon, pa, pa_oe_n, pb, pb_oe_n, dir_a, dir_b, halt, irq, src_run;
  logic [7:0] half;
  int fails, n_compared;

  const_res_pwm_freq_monitor u_const_res_pwm_freq_monitor (
    .clk_sys(clk_sys), .rst(rst),
    .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr),
    .s_axi_wdata(wd), .s_axi_wstrb(ws), .s_axi_wvalid(wv),
    .s_axi_wready(wrdy), .s_axi_bresp(bresp), .s_axi_bvalid(bv),
    .s_axi_bready(br), .s_axi_araddr(ara), .s_axi_arvalid(arv),
    .s_axi_arready(arr), .s_axi_rdata(rdd), .s_axi_rresp(rresp),
    .s_axi_rvalid(rv), .s_axi_rready(rr),
    .freq_monitor_input(mon), .output_pin_a(pa),
    .output_pin_a_oe_n(pa_oe_n), .output_pin_b(pb),
    .output_pin_b_oe_n(pb_oe_n), .pin_a_dir_out(dir_a),
    .pin_b_dir_out(dir_b), .halt(halt), .timer_irq(irq)
  );

  edge_source u_edge_source (
    .clk_sys(clk_sys), .run(src_run), .half(half), .pin_a(pa),
    .pin_a_oe_n(pa_oe_n), .level(mon)
  );

  // ----------------------------------------------------------------
  // Bus and check helpers
  // ----------------------------------------------------------------
  task automatic stop_test;
    $display("compared %0d, mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] e,
                     input string m);
    n_compared++;
    if (g !== e) begin
      fails++;
      $display("mismatch at %0t: %s got %h exp %h", $time, m, g, e);
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d,
                    output logic [1:0] r);
    awa <= a; wd <= d; ws <= 4'hf;
    awv <= 1'b1; wv <= 1'b1; br <= 1'b1;
    // Only the watchdog ends a wait for the answer
    do begin
      @(posedge clk_sys);
      if (awr) awv <= 1'b0;
      if (wrdy) wv <= 1'b0;
    end while (bv !== 1'b1);
    r = bresp;
    br <= 1'b0;
    @(posedge clk_sys);
  endtask

  task automatic w(input logic [11:0] a, input logic [31:0] d);
    logic [1:0] r;
    wr(a, d, r);
    chk({30'h0, r}, {30'h0, RESP_OKAY}, "write response");
  endtask

  task automatic rd(input logic [11:0] a, output logic [31:0] d,
                    output logic [1:0] r);
    ara <= a; arv <= 1'b1; rr <= 1'b1;
    do begin
      @(posedge clk_sys);
      if (arr) arv <= 1'b0;
    end while (rv !== 1'b1);
    d = rdd;
    r = rresp;
    rr <= 1'b0;
    @(posedge clk_sys);
  endtask

  task automatic rchk(input logic [11:0] a, input logic [31:0] e);
    logic [31:0] d;
    logic [1:0] r;
    rd(a, d, r);
    chk(d, e, "read data");
    chk({30'h0, r}, {30'h0, RESP_OKAY}, "read response");
  endtask

  // Counts edges until pin B shows v, at most lim
  task automatic wait_pb(input logic v, input int lim, output int n);
    for (n = 0; n < lim && pb !== v; n++) @(posedge clk_sys);
  endtask

  // One full waveform period on pin B, starting from a rising edge
  task automatic meas(output int hi, output int per);
    int lo;
    wait_pb(1'b0, 1200, lo);
    wait_pb(1'b1, 1200, lo);
    wait_pb(1'b0, 1200, hi);
    wait_pb(1'b1, 1200, lo);
    per = hi + lo;
  endtask

  task automatic cnt_pb(input logic v, output int n);
    n = 0;
    repeat (300) begin
      @(posedge clk_sys);
      if (pb === v) n++;
    end
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset;
    logic [31:0] d;
    logic [1:0] r;
    rchk(A_DIV, 32'h0);
    rchk(A_ON, 32'h0);
    rchk(A_CTL, 32'h0);
    rd(A_BAD, d, r);
    chk({30'h0, r}, {30'h0, RESP_SLVERR}, "unmapped read");
    chk(d, 32'h0, "unmapped data");
    wr(A_BAD, 32'h1, r);
    chk({30'h0, r}, {30'h0, RESP_SLVERR}, "unmapped write");
    w(A_STS, 32'hff);
    rchk(A_STS, 32'h0);
    w(A_DIV, 32'hffff_ff5a);
    rchk(A_DIV, 32'h5a);
    w(A_DIV, 32'h0);
  endtask

  task automatic t_idle;
    dir_a <= 1'b1;
    dir_b <= 1'b1;
    w(A_CTL, 32'h31);
    repeat (4) @(posedge clk_sys);
    chk({31'h0, pb}, 32'h1, "pwm stopped level");
    chk({31'h0, pa}, 32'h1, "pin a level");
    chk({31'h0, pb_oe_n}, 32'h0, "pin b driven");
    dir_b <= 1'b0;
    repeat (4) @(posedge clk_sys);
    chk({31'h0, pb_oe_n}, 32'h1, "pin b as input");
    dir_b <= 1'b1;
    w(A_CTL, 32'h20);
    repeat (4) @(posedge clk_sys);
    chk({31'h0, pb}, 32'h0, "monitor stopped level");
    chk({31'h0, pa_oe_n}, 32'h1, "pin a disabled");
  endtask

  task automatic t_pwm;
    int hi, per;
    w(A_ON, 32'h3);
    w(A_CTL, 32'h37);
    meas(hi, per);
    chk(hi, 3, "high time");
    chk(per, 255, "period");
    chk({31'h0, irq}, 32'h1, "overflow irq");
    rchk(A_CTL, 32'h3f);
    meas(hi, per);
    // Just after an overflow, so no hardware set lands meanwhile
    w(A_CTL, 32'h37);
    rchk(A_CTL, 32'h37);
    w(A_CTL, 32'h3f);
    rchk(A_CTL, 32'h37);
    chk({31'h0, irq}, 32'h0, "irq cleared");
  endtask

  task automatic t_div;
    int hi, per;
    w(A_DIV, 32'h1);
    meas(hi, per);
    meas(hi, per);
    chk(hi, 6, "divided high time");
    chk(per, 510, "divided period");
    w(A_DIV, 32'h0);
    meas(hi, per);
  endtask

  task automatic t_ontime;
    int hi, per, n;
    w(A_ON, 32'd100);
    meas(hi, per);
    repeat (10) @(posedge clk_sys);
    w(A_ON, 32'd20);
    wait_pb(1'b0, 300, n);
    chk(32'(n > 60), 32'h1, "old on-time kept");
    meas(hi, per);
    chk(hi, 20, "new on-time");
    w(A_ON, 32'h0);
    repeat (300) @(posedge clk_sys);
    cnt_pb(1'b1, n);
    chk(n, 0, "on-time zero");
    w(A_ON, 32'hff);
    repeat (300) @(posedge clk_sys);
    cnt_pb(1'b0, n);
    chk(n, 0, "on-time full");
  endtask

  task automatic t_monitor;
    int n;
    w(A_CTL, 32'h0);
    w(A_ON, 32'd20);
    for (int es = 0; es < 2; es++) begin
      w(A_CTL, 32'h0);
      w(A_CTL, 32'h26 | (es << 6));
      src_run <= 1'b1;
      repeat (20) @(posedge clk_sys);
      cnt_pb(1'b1, n);
      chk(n, 0, "fast input stays low");
      rchk(A_CTL, 32'h26 | (es << 6));
    end
    src_run <= 1'b0;
    wait_pb(1'b1, 60, n);
    chk(32'(n >= 12 && n <= 30), 32'h1, "slow input flagged");
    chk({31'h0, irq}, 32'h1, "monitor irq");
    rchk(A_CTL, 32'h6e);
    chk({31'h0, pa_oe_n}, 32'h1, "pin a idle in monitor");
    wait_pb(1'b0, 300, n);
    chk(32'(n >= 225 && n <= 240), 32'h1, "cleared on wrap");
  endtask

  task automatic t_halt;
    logic [31:0] s1, s2;
    logic [1:0] r;
    halt <= 1'b1;
    @(posedge clk_sys);
    rd(A_STS, s1, r);
    repeat (40) @(posedge clk_sys);
    rd(A_STS, s2, r);
    chk(s2, s1, "frozen in halt");
    halt <= 1'b0;
    repeat (10) @(posedge clk_sys);
    rd(A_STS, s2, r);
    chk(32'(s2[7:0] > s1[7:0]), 32'h1, "resumed counting");
  endtask

  task automatic t_feedback;
    int n;
    // Pin A enabled in monitor mode loops the output back as input
    w(A_CTL, 32'h0);
    w(A_CTL, 32'h36);
    wait_pb(1'b1, 100, n);
    chk(32'(n < 100), 32'h1, "output rose");
    wait_pb(1'b0, 20, n);
    chk(32'(n <= 8), 32'h1, "fed back edge clears");
    w(A_CTL, 32'h0);
  endtask

  // Silent monitor input, then on-time and mode changed on the fly
  task automatic t_onfly;
    w(A_ON, 32'd200);
    w(A_CTL, 32'h26);
    repeat (50) @(posedge clk_sys);
    chk({31'h0, pb}, 32'h0, "below threshold");
    w(A_ON, 32'd10);
    chk({31'h0, pb}, 32'h1, "threshold lowered");
    rchk(A_CTL, 32'h2e);
    w(A_CTL, 32'h27);
    chk({31'h0, pb}, 32'h0, "toggle into pwm");
    rchk(A_CTL, 32'h27);
    w(A_CTL, 32'h26);
    chk({31'h0, pb}, 32'h1, "toggle into monitor");
    rchk(A_CTL, 32'h2e);
  endtask

  // ----------------------------------------------------------------
  // Clock, watchdog and main sequence
  // ----------------------------------------------------------------
  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end

  initial begin
    #400000;
    fails++;
    stop_test;
  end

  initial begin
    rst = 1'b1;
    awv = 1'b0; wv = 1'b0; br = 1'b0; arv = 1'b0; rr = 1'b0;
    awa = 12'h0; ara = 12'h0; wd = 32'h0; ws = 4'h0;
    dir_a = 1'b0; dir_b = 1'b0; halt = 1'b0; src_run = 1'b0;
    half = 8'h04;
    fails = 0;
    n_compared = 0;
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    t_reset;
    t_idle;
    t_pwm;
    t_div;
    t_ontime;
    t_monitor;
    t_halt;
    t_feedback;
    t_onfly;
    stop_test;
  end
endmodule
